/* File: verilog/agc_params.svh */
// constants for the gain control loop: address, reset values, codes and counts
`ifndef AGC_PARAMS_SVH
`define AGC_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define AGC_LOOP_SETUP_ADDR 6'h1d
`define AGC_LOOP_SETUP_RESET 8'h91
`define AGC_HYST_LSB 6
`define AGC_WAIT_LSB 4
`define AGC_HOLD_LSB 2
`define AGC_FILT_LSB 0

// ----------------------------------------------------------------
// hold policy codes
// ----------------------------------------------------------------
`define AGC_HOLD_NEVER 2'h0
`define AGC_HOLD_SYNC 2'h1
`define AGC_HOLD_ANALOG 2'h2
`define AGC_HOLD_ALL 2'h3

// ----------------------------------------------------------------
// counts, shifts, dB steps, gains and thresholds (thresholds in deviation units)
// ----------------------------------------------------------------
`define AGC_WAIT_UNIT 6'h08
`define AGC_FSK_SHIFT_BASE 3'h3
`define AGC_OOK_SHIFT 3'h4
`define AGC_OOK_STEP_DB 5'h04
`define AGC_RESET_BOUNDARY 5'h08
`define AGC_RESET_AVG_LEN 7'h10
`define AGC_GAIN_MAX 3'h7
`define AGC_GAIN_RESET 3'h7
`define AGC_HYST_HI 32'h06040302
`define AGC_HYST_LO 32'h0c080402

`endif

/* File: verilog/agc_pkg.sv */
// types shared by the gain control loop
package agc_pkg;

  typedef enum logic {ST_ACCUM, ST_SETTLE} agc_state_t;

  typedef struct packed {
    logic [1:0] hyst;
    logic [1:0] waitSel;
    logic [1:0] holdPolicy;
    logic [1:0] filterSel;
  } agc_cfg_t;

  typedef struct packed {
    agc_state_t state;
    agc_cfg_t cfg;
    logic signed [13:0] accSum;
    logic [5:0] accCnt;
    logic [5:0] settleCnt;
    logic syncSeen;
    logic [2:0] analogGain;
    logic [2:0] digitalGain;
    logic [7:0] readData;
    logic [4:0] ookBoundaryDb;
    logic [6:0] avgLenSamples;
    logic settling;
    logic holdActive;
  } agc_regs_t;

endpackage

/* File: verilog/agc_loop_control.sv */
// gain control loop with its setup register
`include "agc_params.svh"

module agc_loop_control (
  input wire logic clk,                  // 125 MHz receiver clock
  input wire logic reset,                // synchronous, active high
  input wire logic ce,                   // clock enable, freezes all state
  input wire logic [5:0] regAddr,        // register address
  input wire logic regWrite,             // write strobe
  input wire logic [7:0] regWdata,       // write data
  input wire logic sampleValid,          // channel filter sample strobe
  input wire logic signed [7:0] deviation, // magnitude deviation of sample
  input wire logic syncFound,            // sync word detected pulse
  input wire logic rxStart,              // new reception, releases sync hold
  input wire logic ookMode,              // high for on-off keying
  output logic [2:0] analogGain,         // analogue gain step
  output logic [2:0] digitalGain,        // digital gain step
  output logic settling,                 // waiting after a gain change
  output logic holdActive,               // both gains currently held
  output logic [7:0] readData,           // register read data
  output logic [4:0] ookBoundaryDb,      // OOK decision boundary in dB
  output logic [6:0] avgLenSamples       // active averaging length
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // settle length in samples: 8, 16, 24, 32
  function automatic logic [5:0] waitSamples(input logic [1:0] sel);
    waitSamples = 6'({4'h0, sel} + 6'h01) * `AGC_WAIT_UNIT;
  endfunction

  // average length as a shift; OOK uses a fixed length
  function automatic logic [2:0] avgShift(input logic [1:0] sel, input logic ook);
    avgShift = ook ? `AGC_OOK_SHIFT : (`AGC_FSK_SHIFT_BASE + {1'b0, sel});
  endfunction

  function automatic logic [4:0] boundaryDb(input logic [1:0] sel);
    boundaryDb = 5'({3'h0, sel} + 5'h01) * `AGC_OOK_STEP_DB;
  endfunction

  function automatic logic [7:0] hystByte(input logic [31:0] tbl, input logic [1:0] sel);
    hystByte = tbl[{sel, 3'h0} +: 8];
  endfunction

  agc_pkg::agc_regs_t r;
  agc_pkg::agc_regs_t n;
  logic frozenA;
  logic frozenD;
  logic decideNow;
  logic tooHigh;
  logic tooLow;
  logic signed [13:0] sum;
  logic signed [13:0] avg;
  logic [6:0] lenSamples;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // live config is read at each decision so a write acts on the next one
  always_comb
  begin
    n = r;
    frozenA = (r.cfg.holdPolicy == `AGC_HOLD_ANALOG) ||
              (r.cfg.holdPolicy == `AGC_HOLD_ALL) ||
              (r.cfg.holdPolicy == `AGC_HOLD_SYNC && r.syncSeen);
    frozenD = (r.cfg.holdPolicy == `AGC_HOLD_ALL) ||
              (r.cfg.holdPolicy == `AGC_HOLD_SYNC && r.syncSeen);
    lenSamples = 7'(7'h01 << avgShift(r.cfg.filterSel, ookMode));
    sum = r.accSum + 14'(deviation);
    avg = sum >>> avgShift(r.cfg.filterSel, ookMode);
    decideNow = ce && sampleValid && r.state == agc_pkg::ST_ACCUM &&
                ({1'b0, r.accCnt} == lenSamples - 7'h01);
    // dead zone bounds widen with the hysteresis code
    // bounds made signed: an unsigned bound would turn negative averages into huge ones
    tooHigh = avg > $signed(14'(hystByte(`AGC_HYST_HI, r.cfg.hyst)));
    tooLow = avg < -$signed(14'(hystByte(`AGC_HYST_LO, r.cfg.hyst)));
    if (ce)
    begin
      if (regWrite && regAddr == `AGC_LOOP_SETUP_ADDR)
      begin
        n.cfg = agc_pkg::agc_cfg_t'(regWdata);
      end
      n.readData = (regAddr == `AGC_LOOP_SETUP_ADDR) ? r.cfg : 8'h00;
      // a sync arriving with rxStart still counts
      if (syncFound)
      begin
        n.syncSeen = 1'b1;
      end
      else if (rxStart)
      begin
        n.syncSeen = 1'b0;
      end
      n.ookBoundaryDb = boundaryDb(r.cfg.filterSel);
      n.avgLenSamples = lenSamples;
      if (sampleValid)
      begin
        unique case (r.state)
          agc_pkg::ST_ACCUM:
          begin
            n.accSum = sum;
            n.accCnt = r.accCnt + 6'h01;
            if (decideNow)
            begin
              n.accSum = 14'sh0000;
              n.accCnt = 6'h00;
              // analogue gain first, digital picks up when analogue is held
              if (tooHigh && !frozenA && r.analogGain != 3'h0)
              begin
                n.analogGain = r.analogGain - 3'h1;
              end
              else if (tooHigh && !frozenD && r.digitalGain != 3'h0)
              begin
                n.digitalGain = r.digitalGain - 3'h1;
              end
              else if (tooLow && !frozenA && r.analogGain != `AGC_GAIN_MAX)
              begin
                n.analogGain = r.analogGain + 3'h1;
              end
              else if (tooLow && !frozenD && r.digitalGain != `AGC_GAIN_MAX)
              begin
                n.digitalGain = r.digitalGain + 3'h1;
              end
              if (n.analogGain != r.analogGain || n.digitalGain != r.digitalGain)
              begin
                n.state = agc_pkg::ST_SETTLE;
                n.settleCnt = waitSamples(r.cfg.waitSel);
              end
            end
          end
          agc_pkg::ST_SETTLE:
          begin
            n.settleCnt = r.settleCnt - 6'h01;
            if (r.settleCnt == 6'h01)
            begin
              n.state = agc_pkg::ST_ACCUM;
            end
          end
        endcase
      end
      n.settling = (n.state == agc_pkg::ST_SETTLE);
      n.holdActive = frozenA && frozenD;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r <= '{state: agc_pkg::ST_ACCUM, cfg: `AGC_LOOP_SETUP_RESET,
             accSum: 14'sh0000, accCnt: 6'h00, settleCnt: 6'h00, syncSeen: 1'b0,
             analogGain: `AGC_GAIN_RESET, digitalGain: `AGC_GAIN_RESET,
             readData: 8'h00, ookBoundaryDb: `AGC_RESET_BOUNDARY,
             avgLenSamples: `AGC_RESET_AVG_LEN, settling: 1'b0, holdActive: 1'b0};
    end
    else
    begin
      r <= n;
    end
  end

  assign analogGain = r.analogGain;
  assign digitalGain = r.digitalGain;
  assign settling = r.settling;
  assign holdActive = r.holdActive;
  assign readData = r.readData;
  assign ookBoundaryDb = r.ookBoundaryDb;
  assign avgLenSamples = r.avgLenSamples;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  reset_value_a: assert property ($fell(reset) |-> r.cfg == 8'h91)
    else $error("setup register reset value wrong");
  settle_load_a: assert property ($rose(r.settling) |->
      r.settleCnt == 6'({4'h0, $past(r.cfg.waitSel)} + 6'h01) * 6'h08)
    else $error("settle count not loaded from wait field");
  settle_end_a: assert property (ce && sampleValid && r.state == agc_pkg::ST_SETTLE &&
      r.settleCnt == 6'h01 |=> r.state == agc_pkg::ST_ACCUM && !r.settling)
    else $error("settle did not end on last sample");
  normal_adjust_a: assert property (decideNow && tooHigh && r.analogGain != 3'h0 &&
      r.cfg.holdPolicy == 2'h0 |=> r.analogGain == $past(r.analogGain) - 3'h1)
    else $error("normal mode failed to lower gain");
  sync_hold_a: assert property (r.cfg.holdPolicy == 2'h1 && r.syncSeen |=>
      $stable(r.analogGain) && $stable(r.digitalGain))
    else $error("gain moved after sync hold");
  analog_hold_a: assert property (r.cfg.holdPolicy == 2'h2 |=> $stable(r.analogGain))
    else $error("analogue gain moved while held");
  // holdActive only refreshes on an enabled cycle, so look at ce of the cycle before
  all_hold_a: assert property (r.cfg.holdPolicy == 2'h3 |=>
      $stable(r.analogGain) && $stable(r.digitalGain) && (!$past(ce) || r.holdActive))
    else $error("gain moved while fully held");
  avg_length_a: assert property (ce && !ookMode |=>
      r.avgLenSamples == 7'(7'h08 << $past(r.cfg.filterSel)))
    else $error("averaging length mismatch");
  ook_boundary_a: assert property (ce |=>
      r.ookBoundaryDb == 5'({3'h0, $past(r.cfg.filterSel)} + 5'h01) * 5'h04)
    else $error("OOK boundary mismatch");
  reg_write_a: assert property (ce && regWrite && regAddr == 6'h1d |=>
      r.cfg == $past(regWdata))
    else $error("register write not stored");

endmodule // agc_loop_control

/* File: tb/tb_agc_loop_control.sv */
// self-checking bench for the gain loop setup register and the loop itself
`include "agc_params.svh"

module tb_agc_loop_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, ce, regWrite, sampleValid, syncFound, rxStart, ookMode;
  logic [5:0] regAddr;
  logic [7:0] regWdata, readData;
  logic signed [7:0] deviation;
  logic [2:0] analogGain, digitalGain;
  logic settling, holdActive;
  logic [4:0] ookBoundaryDb;
  logic [6:0] avgLenSamples;
  logic [7:0] cfg = 8'h91;
  logic [15:0] lfsrVal = 16'hf89a;
  int miscompares = 0, cmp_count = 0, cycles = 0, expA = 7, expD = 7;
  int hi[4] = '{2, 3, 4, 6};
  int lo[4] = '{2, 4, 8, 12};
  bit synced = 0;

  agc_loop_control dut_u (.clk(clk), .reset(reset), .ce(ce), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .sampleValid(sampleValid),
    .deviation(deviation), .syncFound(syncFound), .rxStart(rxStart), .ookMode(ookMode),
    .analogGain(analogGain), .digitalGain(digitalGain), .settling(settling),
    .holdActive(holdActive), .readData(readData), .ookBoundaryDb(ookBoundaryDb),
    .avgLenSamples(avgLenSamples));

  // ----------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // a backstop only: the settle wait already gives up after 40 samples
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      $display("Error at %0t: watchdog expired", $time);
      wrap_up();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chkReg(input logic [7:0] exp);
    check(readData, exp, "readData");
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    regAddr <= `AGC_LOOP_SETUP_ADDR;
    regWrite <= 1'b1;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    cfg = d;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    repeat (3) @(posedge clk);
    #1 chkReg(exp);
  endtask

  // one sample pulse; the idle value is scrambled so stale data never helps
  task automatic smp(input logic signed [7:0] d);
    @(posedge clk);
    sampleValid <= 1'b1;
    deviation <= d;
    @(posedge clk);
    sampleValid <= 1'b0;
    deviation <= ~d;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // one full averaging block of equal samples, checked against the model
  task automatic decide(input logic signed [7:0] d);
    int p, n, cnt, oldA, oldD;
    bit chg;
    n = ookMode ? 16 : 8 << cfg[1:0];
    repeat (n) smp(d);
    p = cfg[3:2];
    oldA = expA;
    oldD = expD;
    if (!(p == 3 || (p == 1 && synced)))
    begin
      if (d > hi[cfg[7:6]])
      begin
        if (p != 2 && expA > 0)
          expA--;
        else if (expD > 0)
          expD--;
      end
      else if (d < -lo[cfg[7:6]])
      begin
        if (p != 2 && expA < 7)
          expA++;
        else if (expD < 7)
          expD++;
      end
    end
    // a request that no free gain can take (held or at its limit) changes nothing and starts no settle
    chg = (expA != oldA) || (expD != oldD);
    check(8'(analogGain), 8'(expA), "analogGain");
    check(8'(digitalGain), 8'(expD), "digitalGain");
    check(8'(settling), 8'(chg), "settling");
    cnt = 0;
    while (chg && settling === 1'b1 && cnt < 40)
    begin
      smp(8'sh00);
      cnt++;
    end
    if (chg) check(8'(cnt), 8'((cfg[5:4] + 1) * 8), "settle samples");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1; ce = 1'b1; regAddr = 6'h00; regWrite = 1'b0; regWdata = 8'h00;
    sampleValid = 1'b0; deviation = 8'sh00; syncFound = 1'b0; rxStart = 1'b0; ookMode = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(`AGC_LOOP_SETUP_ADDR, 8'h91);
    check(8'(avgLenSamples), 8'h10, "avgLen");
    check(8'(ookBoundaryDb), 8'h08, "boundary");
    repeat (6)
    begin
      lfsrVal = lfsr(lfsrVal);
      wr(lfsrVal[7:0]);
      rd(`AGC_LOOP_SETUP_ADDR, lfsrVal[7:0]);
      rd((lfsrVal[13:8] == 6'h1d) ? 6'h1e : lfsrVal[13:8], 8'h00);
    end
    for (int f = 0; f < 4; f++)
    begin
      wr({6'h00, 2'(f)});
      ookMode <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check(8'(ookBoundaryDb), 8'((f + 1) * 4), "boundary");
      check(8'(avgLenSamples), 8'h10, "ook avgLen");
      @(posedge clk);
      ookMode <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check(8'(avgLenSamples), 8'(8 << f), "avgLen");
    end
    for (int w = 0; w < 4; w++)
    begin
      wr({2'h0, 2'(w), 4'h0});
      decide(8'sd20);
    end
    decide(8'sd2);
    wr(8'hc0);
    decide(8'sd6);
    decide(8'sd7);
    wr(8'h08);
    decide(8'sd20);
    decide(-8'sd20);
    wr(8'h0c);
    repeat (3) @(posedge clk);
    #1 check(8'(holdActive), 8'h01, "holdActive");
    decide(8'sd20);
    wr(8'h04);
    decide(8'sd20);
    @(posedge clk);
    syncFound <= 1'b1;
    @(posedge clk);
    syncFound <= 1'b0;
    synced = 1;
    repeat (2) @(posedge clk);
    #1 check(8'(holdActive), 8'h01, "holdActive");
    decide(-8'sd20);
    @(posedge clk);
    rxStart <= 1'b1;
    @(posedge clk);
    rxStart <= 1'b0;
    synced = 0;
    decide(-8'sd20);
    // clock enable low: a write and samples offered meanwhile must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    regAddr <= `AGC_LOOP_SETUP_ADDR;
    regWrite <= 1'b1;
    regWdata <= 8'hff;
    sampleValid <= 1'b1;
    deviation <= -8'sd20;
    repeat (3) @(posedge clk);
    regWrite <= 1'b0;
    sampleValid <= 1'b0;
    ce <= 1'b1;
    rd(`AGC_LOOP_SETUP_ADDR, cfg);
    decide(-8'sd20);
    wrap_up();
  end
endmodule // tb_agc_loop_control
